// >>> wdt_pkg.sv
package wdt_pkg;
  // byte addresses of the register words
  localparam logic [7:0] csr_addr   = 8'h00;  // control and status
  localparam logic [7:0] count_addr = 8'h04;  // counter view and reload
  localparam logic [7:0] cfg_addr   = 8'h08;  // run and reset select
  // control and status field positions
  localparam int flag_bit      = 7;
  localparam int mode_guard    = 6;
  localparam int mode_bit      = 5;
  localparam int irq_guard     = 4;
  localparam int irq_en_bit    = 3;
  // configuration field positions
  localparam int run_bit       = 0;
  localparam int rst_sel_bit   = 1;
  // reset values and the counter top value
  localparam logic [7:0] count_rst  = 8'h00;
  localparam logic [7:0] count_max  = 8'hff;
  localparam logic [1:0] cfg_rst    = 2'h0;
  // count clock divider: one tick every div_cycles pclk cycles
  localparam logic [3:0] div_cycles = 4'h4;
  localparam logic [3:0] div_last   = div_cycles - 4'h1;

  // control bits held in the control and status register
  typedef struct packed {
    logic wrap_flag;          // counter wrapped
    logic timer_mode_select;  // 0 watchdog, 1 interval
    logic wrap_irq_enable;    // interval interrupt enable
  } csr_t;
  localparam csr_t csr_rst = '{wrap_flag: 1'b0, timer_mode_select: 1'b0, wrap_irq_enable: 1'b0};
endpackage

// >>> wd_count8.sv
`timescale 1ns/1ps
// 8-bit up counter with reload and a wrap pulse
module wd_count8 (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       tick,       // count clock enable
  input  wire logic       load,       // software reload
  input  wire logic [7:0] load_val,   // reload value
  output logic      [7:0] count,      // current count
  output logic            wrap        // ff to 00 this cycle
);
  logic [7:0] count_q;  // counter state
  logic [7:0] count_d;  // next count

  // wrap only when a tick meets the top value; a reload takes priority
  assign wrap    = tick && !load && (count_q == wdt_pkg::count_max);
  assign count_d = load ? load_val : (tick ? count_q + 8'h01 : count_q);
  assign count   = count_q;

  // counter register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= wdt_pkg::count_rst;
    end else begin
      count_q <= count_d;
    end
  end
endmodule // wd_count8

// >>> watchdog_control_status.sv
`timescale 1ns/1ps
// Summary of operation
// - counter wrap sets the flag bit 7
// - watchdog reset clears flag after it sets
// - flag clears by read-one then write-zero
// - mode bit written only when guard 0
// - guard bits 6 and 4 read one
// - irq enable written only when guard 0
// - mode 0 watchdog, 1 interval, reset 0
// - interval interrupt only when enable set
module watchdog_control_status (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             wrap_irq,      // interval interrupt request, level
  output logic             reset_req      // internal reset request, one-cycle pulse
);
  wdt_pkg::csr_t csr_q;        // flag, mode, enable
  wdt_pkg::csr_t csr_d;        // next value
  logic [1:0]    cfg_q;        // run and reset select
  logic          armed_q;      // flag read as one, clear allowed
  logic          armed_d;
  logic          rst_q;        // internal reset request
  logic [31:0]   prdata_q;     // read data captured in setup
  logic          pslverr_q;    // unmapped address seen in setup
  logic [3:0]    div_q;        // count clock divider
  logic          tick;         // one-cycle count enable
  logic [7:0]    count;        // counter value
  logic          wrap;         // counter wrap pulse

  // bus decode
  wire setup     = psel && !penable;
  wire access    = psel && penable;
  wire hit_csr   = (paddr == wdt_pkg::csr_addr);
  wire hit_cnt   = (paddr == wdt_pkg::count_addr);
  wire hit_cfg   = (paddr == wdt_pkg::cfg_addr);
  wire mapped    = hit_csr || hit_cnt || hit_cfg;
  wire wr_csr    = access && pwrite && hit_csr;
  wire rd_csr    = access && !pwrite && hit_csr;
  wire wr_cnt    = access && pwrite && hit_cnt;
  wire wr_cfg    = access && pwrite && hit_cfg;
  // a write of zero clears the flag only after an armed read
  wire flag_clr  = wr_csr && armed_q && !pwdata[wdt_pkg::flag_bit];
  // internal reset only in watchdog mode with reset selected
  wire rst_cause = wrap && !csr_q.timer_mode_select
                   && cfg_q[wdt_pkg::rst_sel_bit];

  // read image: guard bits always one, low bits zero
  wire [7:0] csr_img = {csr_q.wrap_flag, 1'b1, csr_q.timer_mode_select, 1'b1,
                        csr_q.wrap_irq_enable, 3'h0};
  wire [31:0] rd_mux = hit_csr ? {24'h0, csr_img} :
                       hit_cnt ? {24'h0, count} :
                       hit_cfg ? {30'h0, cfg_q} : 32'h0;

  // one wait-free access phase; answer data already registered
  assign pready    = 1'b1;
  assign prdata    = prdata_q;
  assign pslverr   = pslverr_q && access;
  assign reset_req = rst_q;
  // interrupt only in interval mode with enable set
  assign wrap_irq  = csr_q.timer_mode_select && csr_q.wrap_irq_enable
                     && csr_q.wrap_flag;

  // next control and status value
  always_comb begin
    csr_d = csr_q;
    // guarded fields; partial bit writes would corrupt guards
    if (wr_csr && !pwdata[wdt_pkg::mode_guard]) begin
      csr_d.timer_mode_select = pwdata[wdt_pkg::mode_bit];
    end
    if (wr_csr && !pwdata[wdt_pkg::irq_guard]) begin
      csr_d.wrap_irq_enable = pwdata[wdt_pkg::irq_en_bit];
    end
    // clears first so that a wrap in the same cycle wins
    if (flag_clr || rst_q) begin
      csr_d.wrap_flag = 1'b0;
    end
    if (wrap) begin
      csr_d.wrap_flag = 1'b1;
    end
    armed_d = armed_q;
    if (wr_csr || !csr_q.wrap_flag) begin
      armed_d = 1'b0;  // any control and status write ends the read-then-write pair
    end
    // arm only when the word handed back showed the flag set; a wrap landing
    // between setup and access must not arm a clear for an unseen flag
    if (rd_csr && csr_q.wrap_flag && prdata_q[wdt_pkg::flag_bit]) begin
      armed_d = 1'b1;
    end
  end

  // register state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      csr_q   <= wdt_pkg::csr_rst;
      armed_q <= 1'b0;
      rst_q   <= 1'b0;
    end else begin
      csr_q   <= csr_d;
      armed_q <= armed_d;
      rst_q   <= rst_cause;
    end
  end

  // configuration register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= wdt_pkg::cfg_rst;
    end else if (wr_cfg) begin
      cfg_q <= pwdata[1:0];
    end
  end

  // read data and error captured during setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q  <= pwrite ? 32'h0 : rd_mux;
      pslverr_q <= !mapped;
    end
  end

  // count clock divider, runs only while enabled
  assign tick = cfg_q[wdt_pkg::run_bit] && (div_q == wdt_pkg::div_last);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 4'h0;
    end else if (!cfg_q[wdt_pkg::run_bit] || tick) begin
      div_q <= 4'h0;
    end else begin
      div_q <= div_q + 4'h1;
    end
  end

  // the counter itself
  wd_count8 u_count (
    .pclk     (pclk),
    .presetn  (presetn),
    .tick     (tick),
    .load     (wr_cnt),
    .load_val (pwdata[7:0]),
    .count    (count),
    .wrap     (wrap)
  );

  // every check runs on the bus clock and sleeps while reset is held
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // flag: a wrap wins over any clear in the same cycle
  a_wrap_sets_flag: assert property (wrap |=> csr_q.wrap_flag)
    else $error("wrap did not set flag");
  // internal reset wipes the flag the cycle after the wrap
  a_reset_clears_flag: assert property (rst_q && !wrap |=> !csr_q.wrap_flag)
    else $error("internal reset did not clear flag");
  // without an armed read or an internal reset the flag cannot drop
  a_unarmed_keeps_flag: assert property (
    csr_q.wrap_flag && !armed_q && !rst_q |=> csr_q.wrap_flag)
    else $error("flag cleared without armed read");
  a_armed_clear_works: assert property (
    flag_clr && !wrap && !rst_q |=> !csr_q.wrap_flag ##1 !armed_q)
    else $error("armed write of zero failed to clear");
  // writing one to the flag neither clears nor sets it
  a_flag_one_ignored: assert property (
    wr_csr && pwdata[wdt_pkg::flag_bit] && csr_q.wrap_flag && !rst_q |=> csr_q.wrap_flag)
    else $error("write of one cleared flag");
  a_write_never_sets: assert property (
    wr_csr && !csr_q.wrap_flag && !wrap |=> !csr_q.wrap_flag)
    else $error("write set the flag");
  // arming needs a completed read of the register
  a_arm_needs_read: assert property (!armed_q && !rd_csr |=> !armed_q)
    else $error("clear armed without read");

  // mode field follows its guard
  a_mode_guarded: assert property (
    wr_csr && pwdata[wdt_pkg::mode_guard] |=> $stable(csr_q.timer_mode_select))
    else $error("mode changed with guard set");
  a_mode_written: assert property (
    wr_csr && !pwdata[wdt_pkg::mode_guard]
    |=> csr_q.timer_mode_select == $past(pwdata[wdt_pkg::mode_bit]))
    else $error("mode not written with guard clear");
  // guards have no storage, they always read back as one
  a_guard_reads_one: assert property (
    setup && !pwrite && hit_csr
    |=> prdata[wdt_pkg::mode_guard] && prdata[wdt_pkg::irq_guard] && prdata[2:0] == 3'h0)
    else $error("guard bits not read as one");

  // enable field follows its guard
  a_irq_en_guarded: assert property (
    wr_csr && pwdata[wdt_pkg::irq_guard] |=> $stable(csr_q.wrap_irq_enable))
    else $error("enable changed with guard set");
  a_irq_en_written: assert property (
    wr_csr && !pwdata[wdt_pkg::irq_guard]
    |=> csr_q.wrap_irq_enable == $past(pwdata[wdt_pkg::irq_en_bit]))
    else $error("enable not written with guard clear");
  // interrupt request only in interval mode with enable set
  a_irq_follows_wrap: assert property (
    wrap && csr_q.timer_mode_select && csr_q.wrap_irq_enable && !wr_csr
    |=> wrap_irq)
    else $error("interval wrap raised no interrupt");
  a_irq_masked: assert property (!csr_q.wrap_irq_enable |-> !wrap_irq)
    else $error("interrupt with enable clear");
  a_irq_not_watchdog: assert property (!csr_q.timer_mode_select |-> !wrap_irq)
    else $error("interrupt in watchdog mode");

  // reset request: one pulse, only after a watchdog wrap with reset selected
  a_wd_reset_req: assert property (
    wrap && !csr_q.timer_mode_select && cfg_q[wdt_pkg::rst_sel_bit]
    |=> reset_req ##1 !reset_req)
    else $error("watchdog wrap missed reset pulse");
  a_reset_needs_wrap: assert property (!wrap |=> !reset_req)
    else $error("reset pulse without wrap");
  a_interval_no_reset: assert property (
    wrap && csr_q.timer_mode_select |=> !reset_req)
    else $error("interval wrap caused reset");

  // counter wraps from the top value to zero, ticks spaced by the divider
  a_wrap_from_top: assert property (
    wrap |-> count == wdt_pkg::count_max ##1 count == 8'h00)
    else $error("wrap not from top value");
  a_tick_spacing: assert property (tick |=> !tick [*3])
    else $error("count ticks too close");

  // unmapped offsets answer with an error, mapped ones never do
  a_unmapped_error: assert property (access |-> pslverr == !mapped)
    else $error("error response does not match decode");
endmodule // watchdog_control_status

// >>> watchdog_control_status_test.sv
`timescale 1ns/1ps
module watchdog_control_status_test;
  logic        pclk;         // bus clock, 40 ns
  logic        presetn;      // async reset, active low
  logic        psel;         // apb select
  logic        penable;      // apb access phase
  logic        pwrite;       // apb direction
  logic [7:0]  paddr;        // apb byte address
  logic [31:0] pwdata;       // apb write data
  logic [31:0] prdata;       // apb read data
  logic        pready;       // apb ready
  logic        pslverr;      // apb error
  logic        wrap_irq;     // interval interrupt
  logic        reset_req;    // internal reset pulse
  logic [31:0] rd;           // last read data
  logic        err;          // last error response
  logic        rst_seen;     // a reset pulse was seen
  int          error_cnt;    // mismatches
  int          comparisons;  // checks made
  int          cycles;       // timeout counter

  watchdog_control_status dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wrap_irq(wrap_irq), .reset_req(reset_req));

  // free running clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // hang guard, far above the fewer than two hundred cycles the tests need
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      finish_test();
    end
  end

  // sticky record of reset pulses, sampled mid-cycle
  always @(negedge pclk) begin
    if (reset_req === 1'b1) rst_seen = 1'b1;
  end

  // expected control word: guards always read one
  function automatic logic [31:0] csr_v(input logic f, input logic m, input logic e);
    csr_v = 32'h0;
    csr_v[wdt_pkg::flag_bit] = f;
    csr_v[wdt_pkg::mode_guard] = 1'b1;
    csr_v[wdt_pkg::mode_bit] = m;
    csr_v[wdt_pkg::irq_guard] = 1'b1;
    csr_v[wdt_pkg::irq_en_bit] = e;
  endfunction

  // one apb transfer of a whole word, never a partial bit update
  // idle edge after it so the next setup is a fresh assignment
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // read a register and compare it
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // verdict
  task automatic finish_test();
    $display("error_cnt=%0d comparisons=%0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, rst_seen} = '0;
    {error_cnt, comparisons, cycles} = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(wdt_pkg::csr_addr, csr_v(1'b0, 1'b0, 1'b0));
    rd_chk(wdt_pkg::count_addr, 32'h0);
    // guards set: nothing may change; then each clear guard writes its field
    apb(1'b1, wdt_pkg::csr_addr, 32'h78);
    rd_chk(wdt_pkg::csr_addr, csr_v(1'b0, 1'b0, 1'b0));
    apb(1'b1, wdt_pkg::csr_addr, 32'h28);
    rd_chk(wdt_pkg::csr_addr, csr_v(1'b0, 1'b1, 1'b1));
    apb(1'b1, wdt_pkg::csr_addr, 32'h10);
    rd_chk(wdt_pkg::csr_addr, csr_v(1'b0, 1'b0, 1'b1));
    // unmapped address is refused
    apb(1'b0, 8'h0c, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    // interval mode, interrupt enabled
    apb(1'b1, wdt_pkg::csr_addr, 32'h28);
    apb(1'b1, wdt_pkg::count_addr, 32'hfe);
    apb(1'b1, wdt_pkg::cfg_addr, 32'h1);
    for (int i = 0; i < 64 && wrap_irq !== 1'b1; i++) @(negedge pclk);
    @(posedge pclk);
    chk({31'h0, wrap_irq}, 32'h1);
    apb(1'b1, wdt_pkg::cfg_addr, 32'h0);
    chk({31'h0, rst_seen}, 32'h0);
    // write zero without a prior read must not clear
    apb(1'b1, wdt_pkg::csr_addr, 32'h50);
    rd_chk(wdt_pkg::csr_addr, csr_v(1'b1, 1'b1, 1'b1));
    apb(1'b1, wdt_pkg::csr_addr, 32'hd0);
    rd_chk(wdt_pkg::csr_addr, csr_v(1'b1, 1'b1, 1'b1));
    apb(1'b1, wdt_pkg::csr_addr, 32'h50);
    rd_chk(wdt_pkg::csr_addr, csr_v(1'b0, 1'b1, 1'b1));
    chk({31'h0, wrap_irq}, 32'h0);
    // interval mode, interrupt disabled: flag sets, request stays low
    apb(1'b1, wdt_pkg::csr_addr, 32'h20);
    apb(1'b1, wdt_pkg::count_addr, 32'hfe);
    apb(1'b1, wdt_pkg::cfg_addr, 32'h1);
    repeat (24) @(posedge pclk);
    chk({31'h0, wrap_irq}, 32'h0);
    apb(1'b1, wdt_pkg::cfg_addr, 32'h0);
    rd_chk(wdt_pkg::csr_addr, csr_v(1'b1, 1'b1, 1'b0));
    apb(1'b1, wdt_pkg::csr_addr, 32'h50);
    // watchdog mode with reset generation
    apb(1'b1, wdt_pkg::csr_addr, 32'h10);
    apb(1'b1, wdt_pkg::count_addr, 32'hfe);
    apb(1'b1, wdt_pkg::cfg_addr, 32'h3);
    for (int i = 0; i < 64 && reset_req !== 1'b1; i++) @(negedge pclk);
    chk({31'h0, reset_req}, 32'h1);
    @(negedge pclk);
    chk({31'h0, reset_req}, 32'h0);
    chk({31'h0, wrap_irq}, 32'h0);
    @(posedge pclk);
    apb(1'b1, wdt_pkg::cfg_addr, 32'h0);
    rd_chk(wdt_pkg::csr_addr, csr_v(1'b0, 1'b0, 1'b0));
    finish_test();
  end
endmodule // watchdog_control_status_test
